//--- hdl/cfbw_cfg.svh
// Constants for the cipher feedback wrapper and its engine sequencer
`ifndef CFBW_CFG_SVH
`define CFBW_CFG_SVH
`define CFBW_BLK_W 64
`define CFBW_BYTE_W 8
`define CFBW_BYTES 8
`define CFBW_BYTE_IDX_LAST 3'h7
`define CFBW_CLK_PER_BYTE 3
`define CFBW_PH_LAST 2'h2
`define CFBW_PH_STROBE 2'h0
`define CFBW_DES_GROUPS 17
`define CFBW_GRP_LAST 5'h10
`define CFBW_WIDTH_W 7
`define CFBW_WIDTH_MAX 7'h40
`define CFBW_IV_ZERO_MAX 16
`define CFBW_FIFO_DEPTH 4
`endif

//--- hdl/cfbw_pkg.sv
// Types shared by both ends of the cipher feedback wrapper
package cfbw_pkg;
  typedef logic [63:0] cfbw_block_t;
  typedef logic [7:0] cfbw_byte_t;
  typedef logic [6:0] cfbw_width_t;
  typedef enum logic [2:0] {D_IDLE, D_REQ, D_FILL, D_TEXT, D_PUSH} cfbw_dstate_t;
  typedef enum logic [2:0] {E_NOKEY, E_KEY, E_READY, E_DATA, E_RUN, E_UNLOAD} cfbw_estate_t;
endpackage : cfbw_pkg

//--- hdl/cfbw_link_if.sv
// Link between the feedback wrapper and the engine sequencer
interface cfbw_link_if;
  logic eng_ready;
  logic blk_req;
  cfbw_pkg::cfbw_block_t blk_data;
  logic byte_valid;
  cfbw_pkg::cfbw_byte_t byte_data;
  modport stream_end (input eng_ready, output blk_req, output blk_data, input byte_valid, input byte_data);
  modport engine_end (output eng_ready, input blk_req, input blk_data, output byte_valid, output byte_data);
endinterface : cfbw_link_if

//--- hdl/cfbw_stream_end.sv
// Feedback and keystream logic of the cipher feedback wrapper, with its result FIFO
// Contract
// - Both ends share key and initializing vector
// - Key loaded into engine before data
// - Initial block: few zeros then vector
// - Result bytes assembled MSB first into keystream
// - Encrypt: cipher is text XOR keystream MSB
// - Feedback shifts left, cipher enters LSB
// - Each shifted feedback re-encrypted into keystream
// - Decrypt: received cipher feeds feedback register
// - Decrypt: plain is cipher XOR keystream MSB
// - Engine always runs in encrypt direction
// - Keystream use width 1 to 64
// - Feedback width N from 1 to 64
// - Shift and new block after every character
// - Text character width equals cipher width
// - Bit error spoils following 64/N blocks
// - Receiver resynchronises after 64 good bits
// - Throughput falls with narrower feedback
// - Eight byte writes, eight byte reads
// - Three clocks per byte, 17 groups compute
`include "cfbw_cfg.svh"
module cfbw_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = `CFBW_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;

  // Four results may wait here while the sink holds off
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = mem_q[rd_q];
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      wr_q <= push ? AW'(wr_q + 1'b1) : wr_q;
      rd_q <= pop ? AW'(rd_q + 1'b1) : rd_q;
      cnt_q <= cnt_d;
      // Flags registered so the ports come from flops; full and empty stay exact
      in_ready <= (cnt_d != (AW+1)'(DEPTH));
      out_valid <= (cnt_d != '0);
    end
  end
endmodule : cfbw_fifo

module cfbw_stream_end (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic vec_load,
  input wire cfbw_pkg::cfbw_block_t initializing_vector,
  input wire logic decrypt,
  input wire cfbw_pkg::cfbw_width_t char_width,
  input wire logic text_valid,
  output logic text_ready,
  input wire cfbw_pkg::cfbw_block_t text_data,
  output logic res_valid,
  input wire logic res_ready,
  output cfbw_pkg::cfbw_block_t res_data,
  output logic ks_valid,
  cfbw_link_if.stream_end link
);
  import cfbw_pkg::*;
  cfbw_dstate_t state_q;
  cfbw_dstate_t state_d;
  cfbw_block_t fb_q;
  cfbw_block_t ks_q;
  cfbw_block_t res_q;
  logic [2:0] byte_q;
  logic req_q;
  logic fifo_ready;

  // Width 0 or above 64 is clamped, so a character is always 1 to 64 bits
  wire width_zero_w = (char_width == 7'h00);
  wire width_wide_w = (char_width > `CFBW_WIDTH_MAX);
  wire cfbw_width_t n_w = width_zero_w ? 7'h01 : width_wide_w ? `CFBW_WIDTH_MAX : char_width;
  wire cfbw_width_t gap_w = 7'(`CFBW_WIDTH_MAX - n_w);
  wire cfbw_block_t mask_w = {`CFBW_BLK_W{1'b1}} >> gap_w;
  wire cfbw_block_t ks_top_w = ks_q >> gap_w;
  wire cfbw_block_t text_w = text_data & mask_w;
  wire cfbw_block_t xor_w = text_w ^ (ks_top_w & mask_w);
  // Decrypt feeds back the received cipher, encrypt the fresh result
  wire cfbw_block_t cbits_w = decrypt ? text_w : xor_w;
  // Cipher bits sit at the top of the low half, so one shift brings them in
  wire [127:0] cat_w = {fb_q, cbits_w << gap_w} << n_w;
  wire cfbw_block_t fb_next_w = cat_w[127:64];
  wire take_w = (state_q == D_TEXT) && text_valid && text_ready;
  wire fill_last_w = link.byte_valid && (byte_q == `CFBW_BYTE_IDX_LAST);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      D_IDLE:
        if (vec_load)
          state_d = D_REQ;
      D_REQ:
        if (link.eng_ready)
          state_d = D_FILL;
      D_FILL:
        if (fill_last_w)
          state_d = D_TEXT;
      // A new vector here drops the waiting keystream
      D_TEXT:
        if (vec_load)
          state_d = D_REQ;
        else if (take_w)
          state_d = D_PUSH;
      D_PUSH:
        if (fifo_ready)
          state_d = D_REQ;
      default:
        state_d = D_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= D_IDLE;
      req_q <= 1'b0;
      byte_q <= '0;
      text_ready <= 1'b0;
      ks_valid <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      req_q <= (state_q == D_REQ) && link.eng_ready;
      byte_q <= (state_q != D_FILL) ? 3'h0 : link.byte_valid ? 3'(byte_q + 1'b1) : byte_q;
      text_ready <= (state_d == D_TEXT) && !vec_load;
      ks_valid <= (state_d == D_TEXT);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      fb_q <= '0;
      ks_q <= '0;
      res_q <= '0;
    end
    else
    begin
      if (vec_load && (state_q == D_IDLE || state_q == D_TEXT))
        fb_q <= initializing_vector;
      else if (take_w)
        fb_q <= fb_next_w;
      // The first byte in ends at the top once all eight have shifted through
      if ((state_q == D_FILL) && link.byte_valid)
        ks_q <= {ks_q[55:0], link.byte_data};
      if (take_w)
        res_q <= xor_w;
    end
  end

  assign link.blk_req = req_q;
  assign link.blk_data = fb_q;
  // The FIFO stalls the wrapper in D_PUSH when the result sink holds off
  cfbw_fifo #(
    .WIDTH(`CFBW_BLK_W),
    .DEPTH(`CFBW_FIFO_DEPTH)
  ) u_res_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(state_q == D_PUSH),
    .in_ready(fifo_ready),
    .in_data(res_q),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );
endmodule : cfbw_stream_end

//--- hdl/cfbw_engine_end.sv
// Engine sequencer: key load, block load, compute wait and byte unload
`include "cfbw_cfg.svh"
module cfbw_engine_end (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic key_load,
  input wire cfbw_pkg::cfbw_block_t key_value,
  output logic key_done,
  output logic des_wr,
  output logic des_rd,
  output logic des_key_sel,
  output logic des_encrypt,
  output cfbw_pkg::cfbw_byte_t des_wdata,
  input wire cfbw_pkg::cfbw_byte_t des_rdata,
  cfbw_link_if.engine_end link
);
  import cfbw_pkg::*;
  cfbw_estate_t state_q;
  cfbw_estate_t state_d;
  cfbw_block_t sh_q;
  logic [1:0] ph_q;
  logic [2:0] byte_q;
  logic [4:0] grp_q;
  logic bv_q;
  cfbw_byte_t bd_q;
  wire ph_end_w = (ph_q == `CFBW_PH_LAST);
  wire byte_end_w = ph_end_w && (byte_q == `CFBW_BYTE_IDX_LAST);
  wire grp_end_w = ph_end_w && (grp_q == `CFBW_GRP_LAST);
  wire writing_w = (state_q == E_KEY) || (state_q == E_DATA);
  wire busy_w = writing_w || (state_q == E_RUN) || (state_q == E_UNLOAD);
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      E_NOKEY:
        if (key_load)
          state_d = E_KEY;
      E_KEY:
        if (byte_end_w)
          state_d = E_READY;
      E_READY:
        if (key_load)
          state_d = E_KEY;
        else if (link.blk_req)
          state_d = E_DATA;
      E_DATA:
        if (byte_end_w)
          state_d = E_RUN;
      E_RUN:
        if (grp_end_w)
          state_d = E_UNLOAD;
      E_UNLOAD:
        if (byte_end_w)
          state_d = E_READY;
      default:
        state_d = E_NOKEY;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= E_NOKEY;
      ph_q <= '0;
      byte_q <= '0;
      grp_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      ph_q <= (!busy_w || ph_end_w || state_d != state_q) ? 2'h0 : 2'(ph_q + 1'b1);
      byte_q <= (state_d != state_q) ? 3'h0 : ph_end_w ? 3'(byte_q + 1'b1) : byte_q;
      grp_q <= (state_q != E_RUN) ? 5'h00 : ph_end_w ? 5'(grp_q + 1'b1) : grp_q;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sh_q <= '0;
      bv_q <= 1'b0;
      bd_q <= '0;
      des_wr <= 1'b0;
      des_rd <= 1'b0;
      des_key_sel <= 1'b0;
      des_encrypt <= 1'b1;
      key_done <= 1'b0;
    end
    else
    begin
      if (state_d == E_KEY && state_q != E_KEY)
        sh_q <= key_value;
      else if (state_d == E_DATA && state_q != E_DATA)
        sh_q <= link.blk_data;
      else if (writing_w && ph_end_w)
        sh_q <= {sh_q[55:0], 8'h00};
      // Strobe sits in the middle clock so data is settled on both sides of it
      des_wr <= writing_w && (ph_q == `CFBW_PH_STROBE) && (state_d == state_q);
      des_rd <= (state_q == E_UNLOAD) && (ph_q == `CFBW_PH_STROBE);
      bv_q <= (state_q == E_UNLOAD) && ph_end_w;
      if ((state_q == E_UNLOAD) && ph_end_w)
        bd_q <= des_rdata;
      des_key_sel <= (state_d == E_KEY);
      des_encrypt <= 1'b1;
      key_done <= (state_d != E_NOKEY) && (state_d != E_KEY);
    end
  end
  assign des_wdata = sh_q[63:56];
  assign link.eng_ready = (state_q == E_READY) && !key_load;
  assign link.byte_valid = bv_q;
  assign link.byte_data = bd_q;
endmodule : cfbw_engine_end

//--- verification/cfbw_link_props.sv
// Protocol checker for the link between the stream end and the engine end
module cfbw_link_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic eng_ready,
  input wire logic blk_req,
  input wire cfbw_pkg::cfbw_block_t blk_data,
  input wire logic byte_valid,
  input wire cfbw_pkg::cfbw_byte_t byte_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import cfbw_pkg::*;
  logic busy_q;
  logic [2:0] cnt_q;
  wire last_byte = byte_valid && cnt_q == 3'h7;
  always_ff @(posedge clk)
  begin
    if (!rst_n || blk_req)
      cnt_q <= 3'h0;
    else if (byte_valid)
      cnt_q <= cnt_q + 3'h1;
  end
  // Busy spans one whole block, so a second request inside it is caught
  always_ff @(posedge clk)
  begin
    if (!rst_n || last_byte)
      busy_q <= 1'b0;
    else if (blk_req)
      busy_q <= 1'b1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  req_pulse_a: assert property (blk_req |=> !blk_req) else $error("long block request");
  req_ready_a: assert property (blk_req |-> eng_ready) else $error("request while engine busy");
  one_block_a: assert property (blk_req |-> !busy_q) else $error("request inside a block");
  byte_owed_a: assert property (byte_valid |-> busy_q) else $error("byte without request");
  first_byte_a: assert property (blk_req |-> ##[70:100] byte_valid) else $error("first byte late");
  no_early_a: assert property (blk_req |=> !byte_valid [*8]) else $error("byte too early");
  byte_gap_a: assert property (byte_valid && !last_byte |=> !byte_valid [*2] ##1 byte_valid) else $error("gap");
  eng_busy_a: assert property (blk_req |=> !eng_ready [*8]) else $error("engine ready too soon");
  hold_fb_a: assert property (blk_req |=> $stable(blk_data) [*8]) else $error("feedback moved");
  byte_hold_a: assert property ($changed(byte_data) |-> byte_valid) else $error("result byte moved");
  block_time_a: assert property (blk_req |-> ##100 last_byte) else $error("block time off");
  cover property (blk_req);
  cover property (last_byte);
  cover property (byte_valid ##3 byte_valid);
endmodule : cfbw_link_props

//--- verification/cfbw_tb.sv
// Self-checking bench joining the stream end and the engine end
module cfbw_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cfbw_pkg::*;
  localparam cfbw_byte_t PAD = 8'hC3;
  localparam int WIDTHS [4] = '{1, 8, 33, 64};
  logic clk = 1'b0;
  logic rst_n, vec_load, decrypt, text_valid, res_ready, key_load;
  logic text_ready, res_valid, ks_valid, key_done, des_wr, des_rd, des_key_sel, des_encrypt;
  cfbw_width_t char_width;
  cfbw_block_t initializing_vector, text_data, res_data, key_value, fb_m, last_blk;
  cfbw_byte_t des_wdata, des_rdata;
  cfbw_byte_t wb [8];
  cfbw_block_t ct [11];
  logic [2:0] wi, ri, ki;
  cfbw_block_t exp_q [$];
  cfbw_block_t got_q [$];
  int n_errors = 0;
  int total_checks = 0;
  bit started = 1'b0;
  cfbw_link_if link ();
  cfbw_stream_end cfbw_stream_end_i (.clk, .rst_n, .vec_load, .initializing_vector, .decrypt, .char_width,
    .text_valid, .text_ready, .text_data, .res_valid, .res_ready, .res_data, .ks_valid, .link(link));
  cfbw_engine_end cfbw_engine_end_i (.clk, .rst_n, .key_load, .key_value, .key_done, .des_wr, .des_rd,
    .des_key_sel, .des_encrypt, .des_wdata, .des_rdata, .link(link));
  cfbw_link_props cfbw_link_props_i (.clk, .rst_n, .eng_ready(link.eng_ready), .blk_req(link.blk_req),
    .blk_data(link.blk_data), .byte_valid(link.byte_valid), .byte_data(link.byte_data));
  always #5 clk = ~clk;
  task automatic check(input cfbw_block_t got, input cfbw_block_t exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Linear stand-in for the core: keystream is the loaded block XOR a pad
  always @(posedge clk)
  begin
    if (des_wr && des_key_sel)
      check(64'(des_wdata), 64'(key_value[8 * (7 - ki) +: 8]));
    ki <= ki + 3'(des_wr && des_key_sel);
    if (des_wr && !des_key_sel)
      wb[wi] <= des_wdata;
    wi <= wi + 3'(des_wr && !des_key_sel);
    if (des_wr)
      check(64'(des_encrypt), 64'h1);
    des_rdata <= des_rd ? wb[ri] ^ PAD : ~des_rdata;
    ri <= ri + 3'(des_rd);
    if (link.blk_req)
      last_blk <= link.blk_data;
    if (res_valid && res_ready)
      got_q.push_back(res_data);
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic wait_for(input int sel);
    int i;
    for (i = 0; i < 500; i++)
    begin
      @(posedge clk);
      #1;
      if ((sel == 0 ? key_done : sel == 1 ? text_ready : 1'(got_q.size() >= exp_q.size())) === 1'b1)
        break;
    end
    if (i == 500)
    begin
      n_errors++;
      $display("unexpected at %0t: wait %0d timed out, got %h expected %h", $time, sel, 1'b0, 1'b1);
      finish_test();
    end
  endtask : wait_for
  task automatic start(input cfbw_block_t vec, input int n, input logic dec);
    // The first vector meets an idle wrapper, later ones a waiting keystream
    if (started)
      wait_for(1);
    started = 1'b1;
    @(posedge clk);
    vec_load <= 1'b1;
    initializing_vector <= vec;
    char_width <= 7'(n);
    decrypt <= dec;
    @(posedge clk);
    vec_load <= 1'b0;
    fb_m = vec;
    exp_q.delete();
    got_q.delete();
  endtask : start
  task automatic send(input cfbw_block_t t, input int n);
    cfbw_block_t m;
    cfbw_block_t r;
    m = {64{1'b1}} >> (64 - n);
    wait_for(1);
    check(last_blk, fb_m);
    check(64'(ks_valid), 64'h1);
    r = (t ^ ((fb_m ^ {8{PAD}}) >> (64 - n))) & m;
    fb_m = (fb_m << n) | (decrypt ? t & m : r);
    exp_q.push_back(r);
    @(posedge clk);
    text_valid <= 1'b1;
    text_data <= t;
    @(posedge clk);
    text_valid <= 1'b0;
  endtask : send
  task automatic drain();
    @(posedge clk);
    res_ready <= 1'b1;
    wait_for(2);
    foreach (exp_q[k])
      check(got_q[k], exp_q[k]);
  endtask : drain
  initial
  begin
    {rst_n, vec_load, decrypt, text_valid, res_ready, key_load, wi, ri, ki} = '0;
    {char_width, initializing_vector, text_data, des_rdata} = '0;
    key_value = 64'h0123_4567_89AB_CDEF;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    key_load <= 1'b1;
    @(posedge clk);
    key_load <= 1'b0;
    wait_for(0);
    $display("key load test done");
    // Results back up while the sink stalls; the fifth push must wait
    start(64'h0000_1234_5678_9ABC, 8, 1'b0);
    for (int k = 0; k < 5; k++)
      send(64'(8'h41 + k), 8);
    repeat (150) @(posedge clk);
    drain();
    $display("fifo stall test done");
    for (int w = 0; w < 4; w++)
    begin
      start(64'h0000_FEDC_BA98_7654, WIDTHS[w], w[0]);
      send(64'hA5A5_5A5A_0F0F_F0F0, WIDTHS[w]);
      send(64'h1357_9BDF_0246_8ACE, WIDTHS[w]);
      drain();
    end
    $display("width table test done");
    // Width codes 0 and above 64 must act as 1 and 64
    start(64'h0000_FEDC_BA98_7654, 1, 1'b0);
    char_width <= 7'h00;
    send(64'hA5A5_5A5A_0F0F_F0F0, 1);
    drain();
    start(64'h0000_FEDC_BA98_7654, 64, 1'b1);
    char_width <= 7'h7F;
    send(64'h1357_9BDF_0246_8ACE, 64);
    drain();
    $display("width clamp test done");
    start(64'h0000_0F1E_2D3C_4B5A, 8, 1'b0);
    for (int k = 0; k < 11; k++)
      send(64'(k * 17), 8);
    drain();
    foreach (ct[k])
      ct[k] = got_q[k];
    start(64'h0000_0F1E_2D3C_4B5A, 8, 1'b1);
    for (int k = 0; k < 11; k++)
      send(ct[k] ^ 64'(k == 1), 8);
    drain();
    check(64'(got_q[9] !== 64'(9 * 17)), 64'h1);
    check(got_q[10], 64'(10 * 17));
    $display("error extension test done");
    finish_test();
  end
endmodule : cfbw_tb
